// [core/host_port_map.svh]
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS   8
`define INIT_CLEAR_NS   800
`define INIT_CLEAR_CYC  ((`INIT_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLR_CNT_W       16

// ----------------------------------------
// Widths and field positions
// ----------------------------------------
`define EPROM_ADDR_W    22
`define MP_ADDR_W       18
`define DATA_W          32
`define PAR_W           4
`define STAT_W          4
`define STAT_RDY_BIT    7
`define STAT_LSB        3
`define STAT_OE_MASK    32'h000000F8
`define BURST_BEATS     4
`define BEAT_STEP       18'h00004

`endif

// [core/host_port_pkg.sv]
package host_port_pkg;
`include "host_port_map.svh"

  typedef enum logic [3:0] {
    CF_CLEAR = 4'b0001,
    CF_WAIT  = 4'b0010,
    CF_LOAD  = 4'b0100,
    CF_USER  = 4'b1000
  } cfg_state_e;

  typedef enum logic [2:0] {
    MP_IDLE = 3'b001,
    MP_BUS  = 3'b010,
    MP_ACK  = 3'b100
  } mp_state_e;

  typedef enum logic [1:0] {
    SZ_WORD = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_HALF = 2'b10
  } mp_size_e;

  typedef struct packed {
    cfg_state_e                cst;
    mp_state_e                 mst;
    logic [`CLR_CNT_W-1:0]     clr_cnt;
    logic                      wr_q;
    logic                      mclk_q;
    logic [7:0]                cfg_byte;
    logic                      cfg_vld;
    logic                      rclk;
    logic [`EPROM_ADDR_W-1:0]  eaddr;
    logic                      ack_n;
    logic                      err_n;
    logic                      retry;
    logic                      drive;
    logic [`DATA_W-1:0]        dout;
    logic [`PAR_W-1:0]         dpar;
    logic                      req;
    logic                      we;
    logic [`MP_ADDR_W-1:0]     maddr;
    mp_size_e                  msz;
    logic                      mburst;
    logic [1:0]                beat;
    logic [`DATA_W-1:0]        wdata;
  } st_s;

endpackage

// [core/config_and_micro_host_port.sv]
// Operation
// - Ready output shows next config byte accepted
// - Status read shows ready on data bit 7
// - Master parallel drives read strobe to memory
// - Master parallel drives 22-bit memory address
// - Busy-high output high until configuration done
// - Busy-low output low until configuration done
// - Init line driven low while clearing
// - Init held low externally blocks configuration start
// - Selected only when select-n low, select-p high
// - Read strobe low drives status on bits 7:3
// - Write strobe low takes config byte
// - Both strobes low: write wins
// - Strobe high ready, low busy
// - Direction high read, low write
// - Burst-continue negated ends burst data phase
// - Size 01 byte, 10 half, 00 word
// - Ack low once data taken or returned
// - Unused micro port reverts to user I/O
// - Micro transfers timed on micro clock rise
// - Error-n low on internal bus error
// - Retry asks host to rerun cycle
// - One parity bit per data byte
`timescale 1ns/1ns
`default_nettype none
`include "host_port_map.svh"
module config_and_micro_host_port
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  // Configuration control
  input  wire logic                     master_mode_i,
  input  wire logic                     power_good_i,
  input  wire logic                     cfg_done_i,
  input  wire logic                     micro_port_en_i,
  input  wire logic [`STAT_W-1:0]       cfg_status_i,
  output logic                          config_busy_high_o,
  output logic                          config_busy_low_o,
  output logic                          user_io_o,
  // Init open-drain pin
  input  wire logic                     init_n_i,
  output logic                          init_n_o,
  output logic                          init_oe_o,
  // Configuration strobes
  input  wire logic                     chip_select_n_i,
  input  wire logic                     chip_select_p_i,
  input  wire logic                     read_strobe_n_i,
  input  wire logic                     write_strobe_n_i,
  output logic                          config_ready_readclk_o,
  output logic [`EPROM_ADDR_W-1:0]      eprom_address_o,
  // Configuration byte to core
  output logic [7:0]                    cfg_byte_o,
  output logic                          cfg_byte_valid_o,
  input  wire logic                     cfg_byte_ready_i,
  // Shared data pins
  input  wire logic [`DATA_W-1:0]       data_i,
  output logic [`DATA_W-1:0]            data_o,
  output logic [`DATA_W-1:0]            data_oe_o,
  // Micro port
  input  wire logic                     micro_port_clk_i,
  input  wire logic                     micro_port_strobe_n_i,
  input  wire logic                     micro_port_dir_i,
  input  wire logic [`MP_ADDR_W-1:0]    micro_port_addr_i,
  input  wire logic                     micro_port_burst_n_i,
  input  wire logic                     micro_port_burst_cont_i,
  input  wire logic [1:0]               micro_port_size_i,
  input  wire logic [`PAR_W-1:0]        micro_port_parity_i,
  output logic [`PAR_W-1:0]             micro_port_parity_o,
  output logic                          micro_port_ack_n_o,
  output logic                          micro_port_err_n_o,
  output logic                          micro_port_retry_o,
  output logic                          micro_port_oe_o,
  // Internal system bus
  output logic                          sys_req_o,
  output logic                          sys_we_o,
  output logic [`MP_ADDR_W-1:0]         sys_addr_o,
  output logic [1:0]                    sys_size_o,
  output logic [`DATA_W-1:0]            sys_wdata_o,
  input  wire logic [`DATA_W-1:0]       sys_rdata_i,
  input  wire logic                     sys_ack_i,
  input  wire logic                     sys_err_i,
  input  wire logic                     sys_retry_i
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  st_s  st_ff;
  st_s  nxt_st;
  logic sel;
  logic mrise;
  logic async_load;
  logic wr_act;
  logic rd_act;
  logic par_bad;

  assign sel        = !chip_select_n_i && chip_select_p_i;
  assign mrise      = micro_port_clk_i && !st_ff.mclk_q;
  assign async_load = (st_ff.cst == CF_LOAD) && !master_mode_i;
  assign wr_act     = async_load && sel && !write_strobe_n_i;
  // Write overrides a simultaneous read strobe
  assign rd_act     = async_load && sel && !read_strobe_n_i && !wr_act;
  assign par_bad    = micro_port_parity_i != par_of(data_i);

  function automatic logic [`PAR_W-1:0] par_of(input logic [`DATA_W-1:0] d);
    logic [`PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < `PAR_W; i++)
    begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.wr_q   = wr_act;
    nxt_st.mclk_q = micro_port_clk_i;
    if (st_ff.cfg_vld && cfg_byte_ready_i)
    begin
      nxt_st.cfg_vld = 1'b0;
    end
    // Primed in wait too, so a status read in the first load cycle is current
    if (!master_mode_i && (st_ff.cst == CF_WAIT || async_load))
    begin
      nxt_st.dout = '0;
      nxt_st.dout[`STAT_RDY_BIT] = !st_ff.cfg_vld;
      nxt_st.dout[`STAT_RDY_BIT-1:`STAT_LSB] = cfg_status_i;
    end

    unique case (st_ff.cst)
      CF_CLEAR:
      begin
        if (st_ff.clr_cnt != `CLR_CNT_W'(`INIT_CLEAR_CYC - 1))
        begin
          nxt_st.clr_cnt = st_ff.clr_cnt + `CLR_CNT_W'(1);
        end
        else if (power_good_i)
        begin
          nxt_st.cst = CF_WAIT;
        end
      end
      CF_WAIT:
      begin
        // An outside party holding init low keeps us here
        if (init_n_i)
        begin
          nxt_st.cst = CF_LOAD;
        end
      end
      CF_LOAD:
      begin
        if (master_mode_i)
        begin
          // One read strobe per byte; stalls while the core holds a byte
          if (st_ff.rclk)
          begin
            nxt_st.rclk     = 1'b0;
            nxt_st.cfg_byte = data_i[7:0];
            nxt_st.cfg_vld  = 1'b1;
            nxt_st.eaddr    = st_ff.eaddr + `EPROM_ADDR_W'(1);
          end
          else if (!st_ff.cfg_vld && !cfg_done_i)
          begin
            nxt_st.rclk = 1'b1;
          end
        end
        else if (wr_act && !st_ff.wr_q && !st_ff.cfg_vld)
        begin
          // Byte taken on the strobe's leading edge
          nxt_st.cfg_byte = data_i[7:0];
          nxt_st.cfg_vld  = 1'b1;
        end
        if (cfg_done_i)
        begin
          nxt_st.cst  = CF_USER;
          nxt_st.rclk = 1'b0;
        end
      end
      CF_USER:
      begin
      end
    endcase

    unique case (st_ff.mst)
      MP_IDLE:
      begin
        // Strobe low marks the port busy with a cycle
        if (mrise && sel && !micro_port_strobe_n_i && micro_port_en_i
            && st_ff.cst == CF_USER)
        begin
          nxt_st.we     = !micro_port_dir_i;
          nxt_st.maddr  = micro_port_addr_i;
          nxt_st.msz    = mp_size_e'(micro_port_size_i);
          nxt_st.mburst = !micro_port_burst_n_i;
          nxt_st.wdata  = data_i;
          nxt_st.beat   = 2'h0;
          if (!micro_port_dir_i && micro_port_size_i == SZ_WORD && par_bad)
          begin
            nxt_st.ack_n = 1'b0;
            nxt_st.err_n = 1'b0;
            nxt_st.mst   = MP_ACK;
          end
          else
          begin
            nxt_st.req = 1'b1;
            nxt_st.mst = MP_BUS;
          end
        end
      end
      MP_BUS:
      begin
        if (sys_ack_i || sys_err_i || sys_retry_i)
        begin
          nxt_st.req   = 1'b0;
          nxt_st.ack_n = !sys_ack_i || sys_err_i || sys_retry_i;
          nxt_st.err_n = !sys_err_i;
          nxt_st.retry = sys_retry_i && !sys_err_i;
          nxt_st.drive = !st_ff.we;
          nxt_st.dout  = sys_rdata_i;
          nxt_st.dpar  = par_of(sys_rdata_i);
          nxt_st.mst   = MP_ACK;
        end
      end
      MP_ACK:
      begin
        // Answer stands until the next micro clock rise
        if (mrise)
        begin
          nxt_st.ack_n = 1'b1;
          nxt_st.err_n = 1'b1;
          nxt_st.retry = 1'b0;
          nxt_st.drive = 1'b0;
          nxt_st.mst   = MP_IDLE;
          if (st_ff.mburst && micro_port_burst_cont_i && st_ff.err_n
              && !st_ff.retry && st_ff.beat != 2'(`BURST_BEATS - 1))
          begin
            nxt_st.beat  = st_ff.beat + 2'h1;
            nxt_st.maddr = st_ff.maddr + `BEAT_STEP;
            nxt_st.wdata = data_i;
            nxt_st.req   = 1'b1;
            nxt_st.mst   = MP_BUS;
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_ff        <= '0;
      st_ff.cst    <= CF_CLEAR;
      st_ff.mst    <= MP_IDLE;
      st_ff.msz    <= SZ_WORD;
      st_ff.ack_n  <= 1'b1;
      st_ff.err_n  <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign config_busy_high_o = st_ff.cst != CF_USER;
  assign config_busy_low_o  = st_ff.cst == CF_USER;
  assign user_io_o          = (st_ff.cst == CF_USER) && !micro_port_en_i;
  assign init_n_o           = 1'b0;
  assign init_oe_o          = st_ff.cst == CF_CLEAR;
  assign config_ready_readclk_o = master_mode_i ? st_ff.rclk
                                : async_load && !st_ff.cfg_vld;
  assign eprom_address_o    = st_ff.eaddr;
  assign cfg_byte_o         = st_ff.cfg_byte;
  assign cfg_byte_valid_o   = st_ff.cfg_vld;
  assign data_o             = st_ff.dout;
  assign data_oe_o          = rd_act ? `STAT_OE_MASK
                            : (st_ff.drive ? '1 : '0);
  assign micro_port_parity_o = st_ff.dpar;
  assign micro_port_ack_n_o  = st_ff.ack_n;
  assign micro_port_err_n_o  = st_ff.err_n;
  assign micro_port_retry_o  = st_ff.retry;
  assign micro_port_oe_o     = (st_ff.cst == CF_USER) && micro_port_en_i;
  assign sys_req_o           = st_ff.req;
  assign sys_we_o            = st_ff.we;
  assign sys_addr_o          = st_ff.maddr;
  assign sys_size_o          = st_ff.msz;
  assign sys_wdata_o         = st_ff.wdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ack_wait;
    !micro_port_ack_n_o && !mrise;
  endsequence

  sequence s_ack_end;
    (st_ff.mst == MP_ACK) && mrise && !micro_port_burst_cont_i;
  endsequence

  chk_busy_pair: assert property (
    config_busy_high_o != config_busy_low_o
    && (config_busy_high_o == (st_ff.cst != CF_USER)))
    else $error("busy outputs not complementary");

  chk_init_drive: assert property (
    (st_ff.cst == CF_CLEAR) |-> init_oe_o && !init_n_o)
    else $error("init not driven low while clearing");

  chk_init_wait: assert property (
    (st_ff.cst == CF_WAIT) && !init_n_i |=> st_ff.cst == CF_WAIT)
    else $error("configuration left wait while init low");

  chk_sel_only: assert property (
    (st_ff.mst == MP_IDLE) && !sel |=> st_ff.mst == MP_IDLE)
    else $error("cycle started while not selected");

  chk_write_wins: assert property (
    async_load && sel && !write_strobe_n_i |-> data_oe_o == '0)
    else $error("data driven during write strobe");

  chk_status_ready: assert property (
    rd_act |-> data_o[`STAT_RDY_BIT] == !$past(st_ff.cfg_vld))
    else $error("ready status bit wrong");

  chk_eprom_step: assert property (
    $fell(config_ready_readclk_o) && master_mode_i
    |-> eprom_address_o == $past(eprom_address_o) + `EPROM_ADDR_W'(1))
    else $error("memory address did not step");

  chk_ack_hold: assert property (
    s_ack_wait |=> !micro_port_ack_n_o)
    else $error("ack released before micro clock rise");

  chk_read_stable: assert property (
    s_ack_wait ##0 st_ff.drive |=> $stable(data_o) && data_oe_o == '1)
    else $error("read data moved while ack low");

  chk_burst_abort: assert property (
    s_ack_end |=> st_ff.mst == MP_IDLE && !sys_req_o)
    else $error("burst continued after abort");

  chk_read_parity: assert property (
    st_ff.drive |-> micro_port_parity_o == par_of(data_o))
    else $error("read parity mismatch");

endmodule
`default_nettype wire

// [verification/host_master.sv]
`timescale 1ns/1ns
`default_nettype none
module host_master
(
  // Clock
  input  wire logic        ref_clk_i,
  output logic             mclk_o,
  // Request
  output logic             strobe_n_o,
  output logic             dir_o,
  output logic [17:0]      addr_o,
  output logic             burst_n_o,
  output logic             burst_cont_o,
  output logic [1:0]       size_o,
  output logic [3:0]       parity_o,
  output logic [31:0]      wdata_o,
  output logic             wdrive_o,
  // Answer
  input  wire logic        ack_n_i,
  input  wire logic        err_n_i,
  input  wire logic        retry_i,
  input  wire logic [31:0] data_i
);
  logic [2:0]  div_ff = 3'h0;
  logic [31:0] rd;
  logic [2:0]  resp;
  int          got;

  // Lines parked idle; called once by the bench so one process drives them
  task automatic idle;
    strobe_n_o = 1'b1;
    dir_o = 1'b0;
    addr_o = 18'h0;
    burst_n_o = 1'b1;
    burst_cont_o = 1'b0;
    size_o = 2'h0;
    parity_o = 4'h0;
    wdata_o = 32'h0;
    wdrive_o = 1'b0;
  endtask

  // Bus clock runs free, one period per eight system cycles
  always @(negedge ref_clk_i)
  begin
    div_ff <= div_ff + 3'h1;
  end
  assign mclk_o = div_ff[2];

  function automatic logic [3:0] par(input logic [31:0] d);
    return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  // Request held from a falling edge until the falling edge after the rising edge that sees the answer
  task automatic xfer(input logic rw, input logic [17:0] a, input logic [31:0] wd,
                      input logic [1:0] sz, input int beats, input logic badp);
    int   n;
    logic at_fall;
    got = 0;
    resp = 3'h0;
    n = 0;
    at_fall = 1'b0;
    @(negedge mclk_o);
    strobe_n_o <= 1'b0;
    dir_o <= rw;
    addr_o <= a;
    size_o <= sz;
    burst_n_o <= (beats == 1);
    burst_cont_o <= (beats > 1);
    wdata_o <= wd;
    wdrive_o <= ~rw;
    parity_o <= par(wd) ^ {3'h0, badp};
    while (got < beats && n < 12)
    begin
      @(posedge mclk_o);
      at_fall = 1'b0;
      n++;
      if (ack_n_i === 1'b0 || err_n_i === 1'b0 || retry_i === 1'b1)
      begin
        got++;
        rd = data_i;
        resp = {~ack_n_i, ~err_n_i, retry_i};
        if (resp[1:0] != 2'h0)
          n = 12;
        @(negedge mclk_o);
        at_fall = 1'b1;
        // Only while the loop goes on, so the release below is the sole write
        if (got < beats && n < 12)
          burst_cont_o <= (got + 1 < beats);
      end
    end
    if (!at_fall)
      @(negedge mclk_o);
    strobe_n_o <= 1'b1;
    burst_n_o <= 1'b1;
    burst_cont_o <= 1'b0;
    wdrive_o <= 1'b0;
    // Released lines show the inverse so a stale value cannot pass
    wdata_o <= ~wdata_o;
    parity_o <= ~parity_o;
  endtask
endmodule
`default_nettype wire

// [verification/tb_config_and_micro_host_port.sv]
`timescale 1ns/1ns
`default_nettype none
`include "host_port_map.svh"
module tb_config_and_micro_host_port;
  import host_port_pkg::*;
  logic        clk, rst_n, master, pgood, done, mp_en, init_hold;
  logic        cs_n, cs_p, rd_n, wr_n, byte_rdy, busy_h, busy_l, user_io;
  logic        init_o, init_oe, init_w, rclk, bvalid, mclk, mstb_n, mdir;
  logic        mburst_n, mcont, hdrv, mack_n, merr_n, mretry, mp_oe;
  logic        sys_req, sys_we, sys_ack, sys_err, sys_retry, lwe;
  logic [1:0]  msz, sys_size, lsz, rsp;
  logic [3:0]  status, mpar, opar;
  logic [7:0]  cfg_d, cbyte;
  logic [17:0] maddr, sys_addr, laddr;
  logic [21:0] eaddr;
  logic [31:0] d_in, d_out, d_oe, hw, sys_wdata, sys_rdata, lwd;
  int          nreq, bad_count, check_count;

  always #4 clk = ~clk;
  // Open-drain init wire with pull-up
  assign init_w = init_oe ? init_o : ~init_hold;
  assign d_in = (d_oe & d_out) | (~d_oe & (hdrv ? hw : {24'h0, cfg_d}));

  config_and_micro_host_port uut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .master_mode_i(master), .power_good_i(pgood), .cfg_done_i(done),
    .micro_port_en_i(mp_en), .cfg_status_i(status), .config_busy_high_o(busy_h),
    .config_busy_low_o(busy_l), .user_io_o(user_io), .init_n_i(init_w),
    .init_n_o(init_o), .init_oe_o(init_oe), .chip_select_n_i(cs_n),
    .chip_select_p_i(cs_p), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
    .config_ready_readclk_o(rclk), .eprom_address_o(eaddr), .cfg_byte_o(cbyte),
    .cfg_byte_valid_o(bvalid), .cfg_byte_ready_i(byte_rdy), .data_i(d_in),
    .data_o(d_out), .data_oe_o(d_oe), .micro_port_clk_i(mclk),
    .micro_port_strobe_n_i(mstb_n), .micro_port_dir_i(mdir),
    .micro_port_addr_i(maddr), .micro_port_burst_n_i(mburst_n),
    .micro_port_burst_cont_i(mcont), .micro_port_size_i(msz),
    .micro_port_parity_i(mpar), .micro_port_parity_o(opar),
    .micro_port_ack_n_o(mack_n), .micro_port_err_n_o(merr_n),
    .micro_port_retry_o(mretry), .micro_port_oe_o(mp_oe), .sys_req_o(sys_req),
    .sys_we_o(sys_we), .sys_addr_o(sys_addr), .sys_size_o(sys_size),
    .sys_wdata_o(sys_wdata), .sys_rdata_i(sys_rdata), .sys_ack_i(sys_ack),
    .sys_err_i(sys_err), .sys_retry_i(sys_retry));

  host_master host (.ref_clk_i(clk), .mclk_o(mclk), .strobe_n_o(mstb_n),
    .dir_o(mdir), .addr_o(maddr), .burst_n_o(mburst_n), .burst_cont_o(mcont),
    .size_o(msz), .parity_o(mpar), .wdata_o(hw), .wdrive_o(hdrv),
    .ack_n_i(mack_n), .err_n_i(merr_n), .retry_i(mretry), .data_i(d_in));

  // Internal bus responder: one answer pulse per request, recorded for checks
  always @(posedge clk)
  begin
    sys_ack <= 1'b0;
    sys_err <= 1'b0;
    sys_retry <= 1'b0;
    if (!rst_n)
    begin
      sys_rdata <= 32'h0;
      nreq <= 0;
    end
    else if (sys_req === 1'b1 && !(sys_ack || sys_err || sys_retry))
    begin
      sys_ack <= (rsp == 2'h0);
      sys_retry <= (rsp == 2'h1);
      sys_err <= (rsp == 2'h2);
      sys_rdata <= {8'hA5, 6'h0, sys_addr};
      nreq <= nreq + 1;
      laddr <= sys_addr;
      lsz <= sys_size;
      lwe <= sys_we;
      lwd <= sys_wdata;
    end
  end

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start(input logic m);
    int n;
    cyc(1);
    rst_n = 1'b0;
    master = m;
    cyc(6);
    rst_n = 1'b1;
    cyc(50);
    chk(init_oe === 1'b1 && busy_h === 1'b1 && busy_l === 1'b0, "clearing");
    n = 0;
    while (init_oe !== 1'b0 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk(n < 200, "clear never ends");
    if (n >= 200)
      results;
  endtask

  task automatic s_master;
    int n;
    cfg_d = 8'h3C;
    start(1'b1);
    n = 0;
    while (rclk !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk(rclk === 1'b1 && eaddr === 22'h0, "first strobe");
    if (n >= 20)
      results;
    cyc(1);
    chk(rclk === 1'b0 && eaddr === 22'h1, "capture");
    chk(bvalid === 1'b1 && cbyte === 8'h3C, "captured byte");
    cyc(10);
    chk(rclk === 1'b0 && eaddr === 22'h1, "no strobe while held");
    byte_rdy = 1'b1;
    cyc(6);
    byte_rdy = 1'b0;
    chk(eaddr > 22'h1, "address steps");
  endtask

  task automatic s_async;
    init_hold = 1'b1;
    start(1'b0);
    cyc(100);
    chk(rclk === 1'b0, "start while init held");
    init_hold = 1'b0;
    cyc(4);
    chk(rclk === 1'b1, "ready");
    cs_n = 1'b0;
    cs_p = 1'b1;
    rd_n = 1'b0;
    cyc(2);
    chk(d_oe === `STAT_OE_MASK && d_out[7:3] === {1'b1, status}, "status read");
    cfg_d = 8'h5A;
    wr_n = 1'b0;
    cyc(2);
    chk(d_oe === 32'h0 && rclk === 1'b0, "write");
    chk(bvalid === 1'b1 && cbyte === 8'h5A, "write byte");
    rd_n = 1'b1;
    wr_n = 1'b1;
    byte_rdy = 1'b1;
    cyc(1);
    byte_rdy = 1'b0;
    cyc(1);
    chk(bvalid === 1'b0 && rclk === 1'b1, "drained");
    cs_p = 1'b0;
    wr_n = 1'b0;
    cyc(3);
    chk(bvalid === 1'b0, "unselected write");
    wr_n = 1'b1;
    cs_p = 1'b1;
  endtask

  task automatic s_user;
    done = 1'b1;
    cyc(3);
    chk(busy_h === 1'b0 && busy_l === 1'b1, "user");
    chk(user_io === 1'b1 && mp_oe === 1'b0, "user io");
    mp_en = 1'b1;
    cyc(2);
    chk(user_io === 1'b0 && mp_oe === 1'b1, "micro port on");
  endtask

  // A transfer that should be answered; silence is a timeout and ends the run
  task automatic xf(input logic rw, input logic [17:0] a, input logic [31:0] wd,
                    input logic [1:0] sz, input int beats, input logic badp);
    host.xfer(rw, a, wd, sz, beats, badp);
    chk(host.got > 0, "no answer");
    if (host.got == 0)
      results;
  endtask

  task automatic s_micro;
    int r;
    xf(1'b0, 18'h00010, 32'h12345678, SZ_WORD, 1, 1'b0);
    chk(host.resp === 3'b100 && lwe === 1'b1 && lwd === 32'h12345678, "write");
    r = nreq;
    xf(1'b0, 18'h00020, 32'hCAFE0001, SZ_WORD, 1, 1'b1);
    chk(host.resp === 3'b110 && nreq == r, "bad parity");
    for (int i = 0; i < 3; i++)
    begin
      msz_loop(i);
    end
    r = nreq;
    xf(1'b1, 18'h00200, 32'h0, SZ_WORD, 4, 1'b0);
    chk(host.got == 4 && nreq == r + 4 && laddr === 18'h0020C, "burst");
    r = nreq;
    xf(1'b1, 18'h00300, 32'h0, SZ_WORD, 2, 1'b0);
    chk(host.got == 2 && nreq == r + 2 && laddr === 18'h00304, "burst abort");
    rsp = 2'h1;
    xf(1'b1, 18'h00400, 32'h0, SZ_WORD, 1, 1'b0);
    chk(host.resp === 3'b001, "retry");
    rsp = 2'h2;
    xf(1'b0, 18'h00404, 32'h0, SZ_BYTE, 1, 1'b0);
    chk(host.resp === 3'b010, "bus error");
    rsp = 2'h0;
    r = nreq;
    cs_n = 1'b1;
    host.xfer(1'b1, 18'h00408, 32'h0, SZ_WORD, 1, 1'b0);
    chk(host.got == 0 && nreq == r && mack_n === 1'b1, "unselected cycle");
  endtask

  task automatic msz_loop(input int i);
    logic [1:0]  sz;
    logic [17:0] a;
    sz = (i == 0) ? SZ_BYTE : (i == 1) ? SZ_HALF : SZ_WORD;
    a = 18'h00100 + 18'(i);
    xf(1'b1, a, 32'h0, sz, 1, 1'b0);
    chk(host.resp === 3'b100 && lsz === sz && lwe === 1'b0, "read size");
    chk(host.rd === {8'hA5, 6'h0, a}, "read data");
    chk(opar === host.par({8'hA5, 6'h0, a}), "read parity");
  endtask

  initial
  begin
    clk = 1'b0;
    host.idle;
    {rst_n, master, done, mp_en, init_hold, byte_rdy} = 6'h0;
    {pgood, cs_n, rd_n, wr_n} = 4'hF;
    cs_p = 1'b0;
    status = 4'hA;
    cfg_d = 8'h0;
    rsp = 2'h0;
    bad_count = 0;
    check_count = 0;
    s_master;
    s_async;
    s_user;
    s_micro;
    results;
  end
endmodule
`default_nettype wire
